/* File: acs_pkg.sv */
/*
  Constants for the channel-two / drive-sense / detach-sense register slice.
  Assumes a byte-wide register port on a single 100 MHz clock.
*/
// What this block does
// - Bit 7 of channel2_settings powers channel two down when 1, 0 = on.
// - Bits 6:4 pick amplifier gain 6,1,2,3,4,8,12 for codes 000 to 110.
// - Bits 3:0 pick channel two input, codes 0000 to 1001 as listed.
// - Drive-sense bits 7:6 set chop: 00 /16, 10 /2, 11 /4, 01 reserved.
// - Drive-sense bit 5 enables the drive buffer, 0 keeps it off.
// - Drive-sense bit 4 enables drive electrode detach sensing.
// - Drive-sense bits 3:0 join ch2 neg, ch2 pos, ch1 neg, ch1 pos.
// - Detach-sense register at 07h: flips at bits 5,4, enables at 3:0.
// - Each flip bit reverses its channel's excitation current, default 0.
// - Each detach enable selects its electrode for detection, default 0.
package acs_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ACS_OFS_CH2   = 8'h05;
  localparam logic [7:0] ACS_OFS_DRV   = 8'h06;
  localparam logic [7:0] ACS_OFS_LOFF  = 8'h07;
  localparam logic [7:0] ACS_RST_CH2   = 8'h00;
  localparam logic [7:0] ACS_RST_DRV   = 8'h00;
  localparam logic [7:0] ACS_RST_LOFF  = 8'h00;
  localparam logic [7:0] ACS_LOFF_MASK = 8'h3F;
  localparam logic [7:0] ACS_RD_NONE   = 8'h00;

  // ==========================================================
  // Field positions
  localparam int ACS_PD_BIT     = 7;
  localparam int ACS_GAIN_HI    = 6;
  localparam int ACS_GAIN_LO    = 4;
  localparam int ACS_MUX_HI     = 3;
  localparam int ACS_CHOP_HI    = 7;
  localparam int ACS_CHOP_LO    = 6;
  localparam int ACS_BUF_BIT    = 5;
  localparam int ACS_DSENSE_BIT = 4;
  localparam int ACS_CH2_CURRENT_REVERSE_BIT  = 5;
  localparam int ACS_CH1_CURRENT_REVERSE_BIT  = 4;
  localparam int ACS_SEL_C2N    = 3;
  localparam int ACS_SEL_C2P    = 2;
  localparam int ACS_SEL_C1N    = 1;
  localparam int ACS_SEL_C1P    = 0;

  // ==========================================================
  // Decoded values
  localparam int         ACS_MUX_CODES = 10;
  localparam logic [3:0] ACS_MUX_SHORT = 4'h1;
  localparam logic [3:0] ACS_GAIN_BAD  = 4'h0;
  localparam logic [4:0] ACS_CHOP_16   = 5'h10;
  localparam logic [4:0] ACS_CHOP_2    = 5'h02;
  localparam logic [4:0] ACS_CHOP_4    = 5'h04;
  localparam logic [4:0] ACS_CHOP_BAD  = 5'h00;

  // Register-port read latency in clock cycles
  localparam int ACS_RD_LAT = 1;

endpackage : acs_pkg

/* File: acs_cfg_if.sv */
/*
  Carries the three stored register bytes from the register bank to the
  field decoder. Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface acs_cfg_if;
  logic [7:0] ch2;
  logic [7:0] drv;
  logic [7:0] loff;

  // Register bank drives, decoder listens
  modport src (output ch2, output drv, output loff);
  modport dst (input ch2, input drv, input loff);
endinterface : acs_cfg_if

/* File: acs_decode.sv */
/*
  Decodes stored gain, input and chop codes into registered analog
  controls. Assumes synchronous active-high reset on the same clock.
*/
`timescale 1ns/1ps
module acs_decode
  import acs_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  acs_cfg_if.dst                        cfg,
  output      logic [3:0]               ch2_gain_factor,
  output      logic [ACS_MUX_CODES-1:0] ch2_input_onehot,
  output      logic [4:0]               chop_divide
);

  typedef struct packed {
    logic [3:0]               gain;
    logic [ACS_MUX_CODES-1:0] mux;
    logic [4:0]               chop;
  } acs_dec_s;

  acs_dec_s                 st_q, st_d;
  logic [ACS_MUX_CODES-1:0] mux_hit;

  // ==========================================================
  // One select line per defined input code; reserved codes hit none
  for (genvar i = 0; i < ACS_MUX_CODES; i++) begin : g_mux
    assign mux_hit[i] = (cfg.ch2[ACS_MUX_HI:0] == 4'(i));
  end

  // Gain and chop lookup
  always_comb begin
    st_d     = st_q;
    st_d.mux = mux_hit;
    case (cfg.ch2[ACS_GAIN_HI:ACS_GAIN_LO])
      3'h0:    st_d.gain = 4'h6;
      3'h1:    st_d.gain = 4'h1;
      3'h2:    st_d.gain = 4'h2;
      3'h3:    st_d.gain = 4'h3;
      3'h4:    st_d.gain = 4'h4;
      3'h5:    st_d.gain = 4'h8;
      3'h6:    st_d.gain = 4'hC;
      default: st_d.gain = ACS_GAIN_BAD;
    endcase
    case (cfg.drv[ACS_CHOP_HI:ACS_CHOP_LO])
      2'h0:    st_d.chop = ACS_CHOP_16;
      2'h2:    st_d.chop = ACS_CHOP_2;
      2'h3:    st_d.chop = ACS_CHOP_4;
      default: st_d.chop = ACS_CHOP_BAD;
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ch2_gain_factor  = st_q.gain;
  assign ch2_input_onehot = st_q.mux;
  assign chop_divide      = st_q.chop;

  // ==========================================================
  // Checks
  AST_GAIN_SIX: assert property (@(posedge clock) disable iff (sys_rst)
    cfg.ch2[ACS_GAIN_HI:ACS_GAIN_LO] == 3'h0 |=> ch2_gain_factor == 4'h6)
    else $error("gain code 000 did not give factor 6");
  AST_CHOP_RSV: assert property (@(posedge clock) disable iff (sys_rst)
    cfg.drv[ACS_CHOP_HI:ACS_CHOP_LO] == 2'h1 |=> chop_divide == ACS_CHOP_BAD)
    else $error("reserved chop code gave a divider");
  AST_MUX_ONE: assert property (@(posedge clock) disable iff (sys_rst)
    cfg.ch2[ACS_MUX_HI:0] < 4'hA |=> $onehot(ch2_input_onehot))
    else $error("defined input code did not give one select");

endmodule : acs_decode

/* File: acs_regs.sv */
/*
  Register bank for channel-two settings, drive sense and detach sense,
  with decoded controls for the analog side. Assumes a byte register port:
  one-cycle strobes, read data valid the cycle after the read strobe.
*/
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module acs_regs
  import acs_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output      logic [7:0]               reg_rdata,
  output      logic                     ch2_power_off,
  output      logic [2:0]               ch2_amp_gain,
  output      logic [3:0]               ch2_gain_factor,
  output      logic [3:0]               ch2_input_select,
  output      logic [ACS_MUX_CODES-1:0] ch2_input_onehot,
  output      logic [4:0]               chop_divide,
  output      logic                     drive_buffer_on,
  output      logic                     drive_electrode_off_sense,
  output      logic                     drive_sel_ch2_neg,
  output      logic                     drive_sel_ch2_pos,
  output      logic                     drive_sel_ch1_neg,
  output      logic                     drive_sel_ch1_pos,
  output      logic                     ch2_current_reverse,
  output      logic                     ch1_current_reverse,
  output      logic                     detach_sel_ch2_neg,
  output      logic                     detach_sel_ch2_pos,
  output      logic                     detach_sel_ch1_neg,
  output      logic                     detach_sel_ch1_pos
);

  typedef struct packed {
    logic [7:0] ch2;
    logic [7:0] drv;
    logic [7:0] loff;
    logic [7:0] rdata;
  } acs_state_s;

  acs_state_s st_q, st_d;
  acs_cfg_if  cfg ();

  // ==========================================================
  // Register writes and read capture
  always_comb begin
    st_d       = st_q;
    st_d.rdata = ACS_RD_NONE;
    if (reg_wr) begin
      if (reg_addr == ACS_OFS_CH2) begin
        st_d.ch2 = reg_wdata;
      end else if (reg_addr == ACS_OFS_DRV) begin
        st_d.drv = reg_wdata;
      end else if (reg_addr == ACS_OFS_LOFF) begin
        st_d.loff = reg_wdata & ACS_LOFF_MASK;
      end
    end
    if (reg_rd) begin
      if (reg_addr == ACS_OFS_CH2) begin
        st_d.rdata = st_q.ch2;
      end else if (reg_addr == ACS_OFS_DRV) begin
        st_d.rdata = st_q.drv;
      end else if (reg_addr == ACS_OFS_LOFF) begin
        st_d.rdata = st_q.loff & ACS_LOFF_MASK;
      end
    end
  end

  // State register, all fields default to zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q.ch2   <= ACS_RST_CH2;
      st_q.drv   <= ACS_RST_DRV;
      st_q.loff  <= ACS_RST_LOFF;
      st_q.rdata <= ACS_RD_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Field outputs straight from the stored bytes
  assign reg_rdata        = st_q.rdata;
  assign ch2_power_off    = st_q.ch2[ACS_PD_BIT];
  assign ch2_amp_gain     = st_q.ch2[ACS_GAIN_HI:ACS_GAIN_LO];
  assign ch2_input_select = st_q.ch2[ACS_MUX_HI:0];
  assign drive_buffer_on  = st_q.drv[ACS_BUF_BIT];
  assign drive_electrode_off_sense = st_q.drv[ACS_DSENSE_BIT];
  // Electrodes joined into the drive derivation
  assign drive_sel_ch2_neg   = st_q.drv[ACS_SEL_C2N];
  assign drive_sel_ch2_pos   = st_q.drv[ACS_SEL_C2P];
  assign drive_sel_ch1_neg   = st_q.drv[ACS_SEL_C1N];
  assign drive_sel_ch1_pos   = st_q.drv[ACS_SEL_C1P];
  // Excitation current direction per channel
  assign ch2_current_reverse = st_q.loff[ACS_CH2_CURRENT_REVERSE_BIT];
  assign ch1_current_reverse = st_q.loff[ACS_CH1_CURRENT_REVERSE_BIT];
  // Electrodes selected for detach detection
  assign detach_sel_ch2_neg  = st_q.loff[ACS_SEL_C2N];
  assign detach_sel_ch2_pos  = st_q.loff[ACS_SEL_C2P];
  assign detach_sel_ch1_neg  = st_q.loff[ACS_SEL_C1N];
  assign detach_sel_ch1_pos  = st_q.loff[ACS_SEL_C1P];

  // Bytes handed to the decoder
  assign cfg.ch2  = st_q.ch2;
  assign cfg.drv  = st_q.drv;
  assign cfg.loff = st_q.loff;

  // ==========================================================
  // Decoded gain, input select lines and chop divider
  acs_decode u_decode (
    .clock            (clock),
    .sys_rst          (sys_rst),
    .cfg              (cfg),
    .ch2_gain_factor  (ch2_gain_factor),
    .ch2_input_onehot (ch2_input_onehot),
    .chop_divide      (chop_divide)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_wr_ch2;
    reg_wr && reg_addr == ACS_OFS_CH2;
  endsequence

  sequence s_wr_drv;
    reg_wr && reg_addr == ACS_OFS_DRV;
  endsequence

  sequence s_wr_loff;
    reg_wr && reg_addr == ACS_OFS_LOFF;
  endsequence

  // Power-off and gain fields follow the written byte one cycle after the write; the input select line matches the stored code
  AST_PWR_OFF: assert property (
    s_wr_ch2 |=> ch2_power_off == $past(reg_wdata[7]))
    else $error("power-off bit did not follow write");
  AST_GAIN_FLD: assert property (
    s_wr_ch2 |=> ch2_amp_gain == $past(reg_wdata[6:4]))
    else $error("gain field did not follow write");
  AST_MUX_FLD: assert property (
    s_wr_ch2 ##1 !reg_wr[*2] |=>
      ch2_input_onehot[ch2_input_select] || ch2_input_select > 4'h9)
    else $error("input select line does not match code");
  // Decoded chop divider two cycles after a drive-sense write
  AST_CHOP_FLD: assert property (
    reg_wr && reg_addr == ACS_OFS_DRV && reg_wdata[7:6] == 2'h2
      ##1 !(reg_wr && reg_addr == ACS_OFS_DRV)
      |=> chop_divide == ACS_CHOP_2)
    else $error("chop code 10 did not divide by 2");
  AST_CHOP_MAP: assert property (
    reg_wr && reg_addr == ACS_OFS_DRV && reg_wdata[7:6] == 2'h0
      ##1 !(reg_wr && reg_addr == ACS_OFS_DRV)
      |=> chop_divide == ACS_CHOP_16)
    else $error("chop code 00 did not divide by 16");
  AST_BUF_ON: assert property (
    s_wr_drv |=> drive_buffer_on == $past(reg_wdata[5]))
    else $error("drive buffer bit did not follow write");
  AST_DSENSE: assert property (
    s_wr_drv |=> drive_electrode_off_sense == $past(reg_wdata[4]))
    else $error("drive sense bit did not follow write");
  AST_DSEL: assert property (
    s_wr_drv |=> {drive_sel_ch2_neg, drive_sel_ch2_pos,
                  drive_sel_ch1_neg, drive_sel_ch1_pos}
                 == $past(reg_wdata[3:0]))
    else $error("drive selects did not follow write");
  AST_FLIP: assert property (
    s_wr_loff |=> {ch2_current_reverse, ch1_current_reverse}
                  == $past(reg_wdata[5:4]))
    else $error("current reverse bits did not follow write");
  AST_DETACH: assert property (
    s_wr_loff |=> {detach_sel_ch2_neg, detach_sel_ch2_pos,
                   detach_sel_ch1_neg, detach_sel_ch1_pos}
                  == $past(reg_wdata[3:0]))
    else $error("detach selects did not follow write");
  AST_LOFF_TOP: assert property (
    reg_rd && reg_addr == ACS_OFS_LOFF |=> reg_rdata[7:6] == 2'h0)
    else $error("fixed-zero bits read back non-zero");
  AST_RD_ONLY: assert property (
    !reg_rd |=> reg_rdata == ACS_RD_NONE)
    else $error("read data outside its read cycle");
  AST_RST_DEF: assert property (@(posedge clock) disable iff (1'b0)
    sys_rst |=> !ch2_power_off && !drive_buffer_on && reg_rdata == 8'h00)
    else $error("defaults wrong after reset");

  // ==========================================================
  // Read-back checks
  // Read data mirrors the field outputs at the read edge
  AST_RD_CH2: assert property (
    reg_rd && reg_addr == ACS_OFS_CH2 |=>
      reg_rdata == $past({ch2_power_off, ch2_amp_gain, ch2_input_select}))
    else $error("channel two settings read back wrong");
  AST_RD_DRV: assert property (
    reg_rd && reg_addr == ACS_OFS_DRV |=>
      reg_rdata[5:0] == $past({drive_buffer_on, drive_electrode_off_sense,
                               drive_sel_ch2_neg, drive_sel_ch2_pos,
                               drive_sel_ch1_neg, drive_sel_ch1_pos}))
    else $error("drive-sense register read back wrong");
  AST_RD_LOFF: assert property (
    reg_rd && reg_addr == ACS_OFS_LOFF |=>
      reg_rdata == $past({2'h0, ch2_current_reverse, ch1_current_reverse,
                          detach_sel_ch2_neg, detach_sel_ch2_pos,
                          detach_sel_ch1_neg, detach_sel_ch1_pos}))
    else $error("detach-sense register read back wrong");
  AST_RD_UNMAP: assert property (
    reg_rd && reg_addr != ACS_OFS_CH2 && reg_addr != ACS_OFS_DRV &&
      reg_addr != ACS_OFS_LOFF |=> reg_rdata == ACS_RD_NONE)
    else $error("unmapped address read back non-zero");

  // Main scenarios
  COV_PWR_DOWN: cover property (s_wr_ch2 and reg_wdata == 8'h81);
  COV_CHOP_DIV2: cover property (chop_divide == ACS_CHOP_2);
  COV_BUF_ON:   cover property (s_wr_drv and reg_wdata[5]);
  COV_LOFF_RD:  cover property (s_wr_loff ##1 reg_rd &&
                                reg_addr == ACS_OFS_LOFF);

endmodule : acs_regs

/* File: acs_regs_tb_top.sv */
/*
  Self-checking bench for the channel-two, drive-sense and detach-sense
  register bank. Assumes the byte register port with one-cycle strobes
  and read data valid only in the cycle after the read strobe.
*/
`timescale 1ns/1ps
module acs_regs_tb_top
  import acs_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic                     clock;
  logic                     sys_rst;
  logic [7:0]               reg_addr;
  logic [7:0]               reg_wdata;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [7:0]               reg_rdata;
  logic                     ch2_power_off;
  logic [2:0]               ch2_amp_gain;
  logic [3:0]               ch2_gain_factor;
  logic [3:0]               ch2_input_select;
  logic [ACS_MUX_CODES-1:0] ch2_input_onehot;
  logic [4:0]               chop_divide;
  logic                     drive_buffer_on;
  logic                     drive_electrode_off_sense;
  logic                     drive_sel_ch2_neg, drive_sel_ch2_pos;
  logic                     drive_sel_ch1_neg, drive_sel_ch1_pos;
  logic                     ch2_current_reverse, ch1_current_reverse;
  logic                     detach_sel_ch2_neg, detach_sel_ch2_pos;
  logic                     detach_sel_ch1_neg, detach_sel_ch1_pos;
  int                       error_cnt;
  int                       checked;
  logic [3:0] gain_exp [0:7] = '{4'h6, 4'h1, 4'h2, 4'h3,
                                 4'h4, 4'h8, 4'hC, 4'h0};
  logic [4:0] chop_exp [0:3] = '{5'h10, 5'h00, 5'h02, 5'h04};
  logic [7:0] drv_pat  [0:3] = '{8'h35, 8'h6A, 8'hA5, 8'hDA};
  logic [7:0] loff_pat [0:2] = '{8'h3F, 8'h16, 8'h29};

  // ==========================================================
  // Design under test
  acs_regs DUT (
    .clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ch2_power_off, .ch2_amp_gain, .ch2_gain_factor, .ch2_input_select,
    .ch2_input_onehot, .chop_divide, .drive_buffer_on,
    .drive_electrode_off_sense, .drive_sel_ch2_neg, .drive_sel_ch2_pos,
    .drive_sel_ch1_neg, .drive_sel_ch1_pos, .ch2_current_reverse,
    .ch1_current_reverse, .detach_sel_ch2_neg, .detach_sel_ch2_pos,
    .detach_sel_ch1_neg, .detach_sel_ch1_pos
  );

  // ==========================================================
  // Clock at 100 MHz
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string name, input logic [9:0] exp,
                     input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk

  // Write, then wait until decoded outputs have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
    #1;
  endtask : wr

  // Read, compare, then check the data bus returns to idle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", {2'h0, exp}, {2'h0, reg_rdata});
    @(posedge clock);
    #1;
    chk("rdata_idle", 10'h000, {2'h0, reg_rdata});
  endtask : rd

  task automatic conclude;
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // ==========================================================
  // Watchdog against a hung sequence
  initial begin
    repeat (3000) @(posedge clock);
    error_cnt++;
    conclude();
  end

  // ==========================================================
  // Main test sequence
  initial begin
    logic [9:0] oh;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    // Defaults after reset
    chk("power_off", 10'h000, {9'h0, ch2_power_off});
    chk("gain_factor", 10'h006, {6'h0, ch2_gain_factor});
    chk("onehot", 10'h001, ch2_input_onehot);
    chk("chop", 10'h010, {5'h0, chop_divide});
    chk("buf", 10'h000, {9'h0, drive_buffer_on});
    chk("dsense", 10'h000, {9'h0, drive_electrode_off_sense});
    rd(ACS_OFS_CH2, 8'h00);
    rd(ACS_OFS_DRV, 8'h00);
    rd(ACS_OFS_LOFF, 8'h00);
    // Every gain code, including the unused one
    for (int g = 0; g < 8; g++) begin
      wr(ACS_OFS_CH2, {1'b0, 3'(g), 4'h0});
      chk("amp_gain", 10'(g), {7'h0, ch2_amp_gain});
      chk("gain_factor", {6'h0, gain_exp[g]}, {6'h0, ch2_gain_factor});
    end
    // Every defined input code; reserved codes are never written
    for (int i = 0; i < ACS_MUX_CODES; i++) begin
      wr(ACS_OFS_CH2, {4'h0, 4'(i)});
      oh = 10'h001 << i;
      chk("input_sel", 10'(i), {6'h0, ch2_input_select});
      chk("onehot", oh, ch2_input_onehot);
    end
    // Power down with inputs shorted, then back on
    wr(ACS_OFS_CH2, 8'h81);
    chk("power_off", 10'h001, {9'h0, ch2_power_off});
    chk("input_sel", {6'h0, ACS_MUX_SHORT}, {6'h0, ch2_input_select});
    rd(ACS_OFS_CH2, 8'h81);
    wr(ACS_OFS_CH2, 8'h01);
    chk("power_off", 10'h000, {9'h0, ch2_power_off});
    // Drive-sense patterns covering every chop code
    for (int k = 0; k < 4; k++) begin
      wr(ACS_OFS_DRV, drv_pat[k]);
      chk("chop", {5'h0, chop_exp[k]}, {5'h0, chop_divide});
      chk("buf", {9'h0, drv_pat[k][5]}, {9'h0, drive_buffer_on});
      chk("dsense", {9'h0, drv_pat[k][4]},
          {9'h0, drive_electrode_off_sense});
      chk("drv_sel", {6'h0, drv_pat[k][3:0]},
          {6'h0, drive_sel_ch2_neg, drive_sel_ch2_pos,
           drive_sel_ch1_neg, drive_sel_ch1_pos});
      rd(ACS_OFS_DRV, drv_pat[k]);
    end
    // Detach-sense patterns, fixed-zero top bits written as zero
    for (int k = 0; k < 3; k++) begin
      wr(ACS_OFS_LOFF, loff_pat[k]);
      chk("flips", {8'h0, loff_pat[k][5:4]},
          {8'h0, ch2_current_reverse, ch1_current_reverse});
      chk("detach_sel", {6'h0, loff_pat[k][3:0]},
          {6'h0, detach_sel_ch2_neg, detach_sel_ch2_pos,
           detach_sel_ch1_neg, detach_sel_ch1_pos});
      rd(ACS_OFS_LOFF, loff_pat[k] & 8'h3F);
    end
    // Unmapped addresses are ignored and read as zero
    wr(8'h08, 8'hFF);
    wr(8'h04, 8'hFF);
    rd(8'h08, 8'h00);
    rd(8'h04, 8'h00);
    rd(ACS_OFS_LOFF, 8'h29);
    // Read right behind a write to the same register
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= ACS_OFS_CH2;
    reg_wdata <= 8'h59;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("rdata_b2b", 10'h059, {2'h0, reg_rdata});
    // Reset in mid-run clears the stored fields
    wr(ACS_OFS_DRV, 8'hFF);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    chk("buf", 10'h000, {9'h0, drive_buffer_on});
    chk("power_off", 10'h000, {9'h0, ch2_power_off});
    rd(ACS_OFS_DRV, 8'h00);
    rd(ACS_OFS_CH2, 8'h00);
    chk("gain_factor", 10'h006, {6'h0, ch2_gain_factor});
    chk("chop", 10'h010, {5'h0, chop_divide});
    chk("onehot", 10'h001, ch2_input_onehot);
    conclude();
  end

endmodule : acs_regs_tb_top
